// *** enc_pkg.sv ***
package enc_pkg;
  // ==========================================================
  // register byte offsets on the APB bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IOC_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] POS_OFS = 8'h0C;
  localparam logic [7:0] IC_OFS = 8'h10;
  localparam logic [7:0] GEC_OFS = 8'h14;
  localparam logic [7:0] LEC_OFS = 8'h18;
  // ==========================================================
  // control register fields
  localparam int SIDL_BIT = 13;
  localparam int MODE_LSB = 10;
  localparam int IMV_LSB = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h3F00;
  // ==========================================================
  // i/o control register fields
  localparam int HCAP_BIT = 15;
  localparam int FLT_BIT = 14;
  localparam int DIV_LSB = 11;
  localparam int OUTF_LSB = 9;
  localparam int SWAP_BIT = 8;
  localparam int INV_LSB = 4;
  localparam logic [15:0] IOC_WMASK = 16'hFFF0;
  // ==========================================================
  // status register: flag at odd bit, its enable one below
  localparam int GE_FLAG = 13;
  localparam int GE_EN = 12;
  localparam int LE_FLAG = 11;
  localparam int LE_EN = 10;
  localparam int POSOV_FLAG = 9;
  localparam int INIT_FLAG = 7;
  localparam int VELOV_FLAG = 5;
  localparam int HOME_FLAG = 3;
  localparam int HOME_EN = 2;
  localparam int IDX_FLAG = 1;
  localparam logic [15:0] FLAG_MASK = 16'h2AAA;
  localparam logic [15:0] EN_MASK = 16'h1555;
  // ==========================================================
  // reset values and position overflow limits
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] IOC_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [31:0] POS_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] POS_MIN = 32'h8000_0000;
  // ==========================================================
  // counter initialisation modes
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000, MODE_IDX_CLR = 3'b001, MODE_IDX_LOAD = 3'b010,
    MODE_HOME1 = 3'b011, MODE_HOME2 = 3'b100, MODE_GE_CLR = 3'b101,
    MODE_BOUNDS = 3'b110, MODE_MODULO = 3'b111
  } init_mode_t;
  // compare pin selection
  localparam logic [1:0] OUTF_OFF = 2'h0;
  localparam logic [1:0] OUTF_GE = 2'h1;
  localparam logic [1:0] OUTF_LE = 2'h2;
  localparam logic [1:0] OUTF_ANY = 2'h3;
endpackage

// *** encoder_position_compare_init.sv ***
`timescale 1ns/100ps
module encoder_position_compare_init (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // encoder pins
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_pulse_input,
  input wire logic home_input,
  // from the external quadrature decoder and velocity counter
  input wire logic count_up_pulse,
  input wire logic count_down_pulse,
  input wire logic vel_ovf_event,
  // power state
  input wire logic sleep_mode,
  input wire logic idle_mode,
  // outputs
  output logic phase_a_dec,
  output logic phase_b_dec,
  output logic compare_out_pin,
  output logic irq
);

  // ==========================================================
  // registers and helpers
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] ioc_r, ioc_nxt;
  logic [15:0] stat_r, stat_nxt;
  logic [31:0] pos_r, pos_nxt;
  logic [31:0] ic_r, ic_nxt;
  logic [31:0] gec_r, gec_nxt;
  logic [31:0] lec_r, lec_nxt;
  logic idx_block_r, idx_block_nxt;
  logic home_prev_r, home_prev_nxt;
  logic [1:0] home_seq_r, home_seq_nxt;
  logic cmp_r, cmp_nxt;
  logic [1:0] dec_r, dec_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [6:0] div_cnt_r, div_cnt_nxt;

  logic run, tick;
  logic [3:0] raw_in;
  logic [3:0] filt;
  logic [2:0] mode;
  logic ge_now, le_now;
  logic idx_ev, home_ev;
  logic wr_en, rd_setup, up, down;

  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == enc_pkg::CTRL_OFS) || (a == enc_pkg::IOC_OFS) ||
               (a == enc_pkg::STAT_OFS) || (a == enc_pkg::POS_OFS) ||
               (a == enc_pkg::IC_OFS) || (a == enc_pkg::GEC_OFS) ||
               (a == enc_pkg::LEC_OFS);
  endfunction

  // stopped in sleep, or in idle when the stop-in-idle bit is set
  assign run = !sleep_mode &&
               !(idle_mode && ctrl_r[enc_pkg::SIDL_BIT]);
  assign mode = ctrl_r[enc_pkg::MODE_LSB +: 3];
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign up = count_up_pulse && !count_down_pulse;
  assign down = count_down_pulse && !count_up_pulse;

  // ==========================================================
  // input conditioning and noise filters
  assign raw_in = {home_input, index_pulse_input, phase_b_input,
                   phase_a_input} ^ ioc_r[enc_pkg::INV_LSB +: 4];

  // divider only advances while running, so a stopped block keeps its phase
  always_comb
    div_cnt_nxt = run ? div_cnt_r + 7'h01 : div_cnt_r;
  assign tick = (div_cnt_r & div_mask(ioc_r[enc_pkg::DIV_LSB +: 3])) ==
                div_mask(ioc_r[enc_pkg::DIV_LSB +: 3]);

  always_ff @(posedge clk)
    div_cnt_r <= rst ? 7'h00 : div_cnt_nxt;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_filt
      logic [2:0] samp_r, samp_nxt;
      logic f_r, f_nxt;
      always_comb
      begin
        samp_nxt = samp_r;
        f_nxt = f_r;
        // inputs ignored while stopped
        if (!run)
          f_nxt = f_r;
        else if (!ioc_r[enc_pkg::FLT_BIT])
        begin
          samp_nxt = {3{raw_in[i]}};
          f_nxt = raw_in[i];
        end
        else if (tick)
        begin
          samp_nxt = {samp_r[1:0], raw_in[i]};
          if (samp_nxt == 3'h7 || samp_nxt == 3'h0)
            f_nxt = samp_nxt[0];
        end
      end
      always_ff @(posedge clk)
      begin
        samp_r <= rst ? 3'h0 : samp_nxt;
        f_r <= rst ? 1'b0 : f_nxt;
      end
      assign filt[i] = f_r;
    end
  endgenerate

  // ==========================================================
  // comparator and event qualification
  assign ge_now = $signed(pos_r) >= $signed(gec_r);
  assign le_now = $signed(pos_r) <= $signed(lec_r);
  assign idx_ev = run && filt[2] && !idx_block_r &&
                  (filt[1:0] == ctrl_r[enc_pkg::IMV_LSB +: 2]);
  assign home_ev = run && filt[3] && !home_prev_r;

  // ==========================================================
  // main state: counter, registers, flags, bus
  always_comb
  begin
    logic [31:0] counted;
    logic load_done;
    logic pos_ov;
    counted = pos_r;
    load_done = 1'b0;
    pos_ov = 1'b0;
    ctrl_nxt = ctrl_r;
    ioc_nxt = ioc_r;
    stat_nxt = stat_r;
    ic_nxt = ic_r;
    gec_nxt = gec_r;
    lec_nxt = lec_r;
    home_seq_nxt = home_seq_r;
    // block re-arms only once index falls
    idx_block_nxt = run ? (idx_ev || (idx_block_r && filt[2]))
                        : idx_block_r;
    home_prev_nxt = run ? filt[3] : home_prev_r;
    if (run && up)
    begin
      counted = pos_r + 32'h0000_0001;
      pos_ov = (pos_r == enc_pkg::POS_MAX);
    end
    else if (run && down)
    begin
      counted = pos_r - 32'h0000_0001;
      pos_ov = (pos_r == enc_pkg::POS_MIN);
    end
    pos_nxt = counted;
    if (run)
    begin
      case (mode)
        enc_pkg::MODE_IDX_CLR: if (idx_ev) pos_nxt = enc_pkg::WORD_RST;
        enc_pkg::MODE_IDX_LOAD:
        begin
          if (idx_ev)
          begin
            pos_nxt = ic_r;
            load_done = 1'b1;
          end
        end
        enc_pkg::MODE_HOME1, enc_pkg::MODE_HOME2:
        begin
          if (idx_ev && home_seq_r != 2'h0 &&
              (mode == enc_pkg::MODE_HOME1 || home_seq_r == 2'h2))
          begin
            pos_nxt = ic_r;
            load_done = 1'b1;
          end
          if (home_ev)
            home_seq_nxt = 2'h1;
          else if (idx_ev && home_seq_r == 2'h1)
            home_seq_nxt = 2'h2;
        end
        enc_pkg::MODE_GE_CLR:
          if (pos_r == gec_r) pos_nxt = enc_pkg::WORD_RST;
        enc_pkg::MODE_BOUNDS:
        begin
          if (up && pos_r == gec_r) pos_nxt = lec_r;
          else if (down && pos_r == lec_r) pos_nxt = gec_r;
        end
        enc_pkg::MODE_MODULO:
        begin
          if (idx_ev) pos_nxt = enc_pkg::WORD_RST;
          else if (up && pos_r == ic_r) pos_nxt = lec_r;
          else if (down && pos_r == lec_r) pos_nxt = ic_r;
        end
        default: pos_nxt = counted;
      endcase
    end
    if (mode != enc_pkg::MODE_HOME1 && mode != enc_pkg::MODE_HOME2)
      home_seq_nxt = 2'h0;
    if (load_done || load_done && home_ev)
      home_seq_nxt = 2'h0;
    if (load_done)
      ctrl_nxt[enc_pkg::MODE_LSB +: 3] = 3'h0;
    // ---- software writes; flags are write-one-to-clear
    if (wr_en)
    begin
      case (paddr)
        enc_pkg::CTRL_OFS: ctrl_nxt = pwdata[15:0] & enc_pkg::CTRL_WMASK;
        enc_pkg::IOC_OFS: ioc_nxt = pwdata[15:0] & enc_pkg::IOC_WMASK;
        enc_pkg::STAT_OFS:
          stat_nxt = (stat_r & ~(pwdata[15:0] & enc_pkg::FLAG_MASK) &
                      enc_pkg::FLAG_MASK) | (pwdata[15:0] & enc_pkg::EN_MASK);
        enc_pkg::POS_OFS: pos_nxt = pwdata;
        enc_pkg::IC_OFS: ic_nxt = pwdata;
        enc_pkg::GEC_OFS: gec_nxt = pwdata;
        enc_pkg::LEC_OFS: lec_nxt = pwdata;
        default: ctrl_nxt = ctrl_nxt; // unmapped writes are dropped
      endcase
    end
    // home capture after the bus so the hardware event is not lost
    if (home_ev && ioc_r[enc_pkg::HCAP_BIT])
      ic_nxt = pos_r;
    // sticky events: setting wins over a same-cycle clear
    if (run)
    begin
      stat_nxt[enc_pkg::GE_FLAG] = stat_nxt[enc_pkg::GE_FLAG] | ge_now;
      stat_nxt[enc_pkg::LE_FLAG] = stat_nxt[enc_pkg::LE_FLAG] | le_now;
      stat_nxt[enc_pkg::POSOV_FLAG] = stat_nxt[enc_pkg::POSOV_FLAG] | pos_ov;
      stat_nxt[enc_pkg::VELOV_FLAG] = stat_nxt[enc_pkg::VELOV_FLAG] |
                                      vel_ovf_event;
      stat_nxt[enc_pkg::INIT_FLAG] = stat_nxt[enc_pkg::INIT_FLAG] | load_done;
      stat_nxt[enc_pkg::HOME_FLAG] = stat_nxt[enc_pkg::HOME_FLAG] | home_ev;
      stat_nxt[enc_pkg::IDX_FLAG] = stat_nxt[enc_pkg::IDX_FLAG] | idx_ev;
    end
    irq_nxt = |({1'b0, stat_nxt[15:1]} & stat_nxt & enc_pkg::EN_MASK);
    case (ioc_r[enc_pkg::OUTF_LSB +: 2])
      enc_pkg::OUTF_GE: cmp_nxt = ge_now;
      enc_pkg::OUTF_LE: cmp_nxt = le_now;
      enc_pkg::OUTF_ANY: cmp_nxt = ge_now || le_now;
      default: cmp_nxt = 1'b0;
    endcase
    dec_nxt = ioc_r[enc_pkg::SWAP_BIT] ? {filt[0], filt[1]}
                                       : {filt[1], filt[0]};
    // read data captured in the setup phase, shown in the access phase
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (rd_setup)
    begin
      pslverr_nxt = !addr_hit(paddr);
      case (paddr)
        enc_pkg::CTRL_OFS: prdata_nxt = {16'h0000, ctrl_r};
        enc_pkg::IOC_OFS: prdata_nxt = {16'h0000, ioc_r[15:4], filt};
        enc_pkg::STAT_OFS: prdata_nxt = {16'h0000, stat_r};
        enc_pkg::POS_OFS: prdata_nxt = pos_r;
        enc_pkg::IC_OFS: prdata_nxt = ic_r;
        enc_pkg::GEC_OFS: prdata_nxt = gec_r;
        enc_pkg::LEC_OFS: prdata_nxt = lec_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // every register back to its reset value
      ctrl_r <= enc_pkg::CTRL_RST;
      ioc_r <= enc_pkg::IOC_RST;
      stat_r <= enc_pkg::STAT_RST;
      pos_r <= enc_pkg::WORD_RST;
      ic_r <= enc_pkg::WORD_RST;
      gec_r <= enc_pkg::WORD_RST;
      lec_r <= enc_pkg::WORD_RST;
      idx_block_r <= 1'b0;
      home_prev_r <= 1'b0;
      home_seq_r <= 2'h0;
      cmp_r <= 1'b0;
      dec_r <= 2'h0;
      irq_r <= 1'b0;
      prdata_r <= enc_pkg::WORD_RST;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ioc_r <= ioc_nxt;
      stat_r <= stat_nxt;
      pos_r <= pos_nxt;
      ic_r <= ic_nxt;
      gec_r <= gec_nxt;
      lec_r <= lec_nxt;
      idx_block_r <= idx_block_nxt;
      home_prev_r <= home_prev_nxt;
      home_seq_r <= home_seq_nxt;
      cmp_r <= cmp_nxt;
      dec_r <= dec_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && psel && penable;
  assign phase_a_dec = dec_r[0];
  assign phase_b_dec = dec_r[1];
  assign compare_out_pin = cmp_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_ge_flag_set: assert property (
    run && ge_now |=> stat_r[enc_pkg::GE_FLAG])
    else $error("ge flag not set on compare hit");
  chk_compare_pin: assert property (
    ioc_r[10:9] == enc_pkg::OUTF_LE && le_now |=> compare_out_pin)
    else $error("compare pin missed le hit");
  chk_index_once: assert property (
    idx_ev |=> !idx_ev [*2])
    else $error("second index event from one pulse");
  chk_mode1_clear: assert property (
    mode == 3'h1 && idx_ev && !wr_en |=> pos_r == 32'h0000_0000)
    else $error("mode 1 did not clear position");
  chk_mode2_load: assert property (
    mode == 3'h2 && idx_ev && !wr_en |=>
      pos_r == $past(ic_r) && ctrl_r[12:10] == 3'h0)
    else $error("mode 2 load or mode clear failed");
  chk_mode5_clear: assert property (
    run && mode == 3'h5 && pos_r == gec_r && !wr_en |=>
      pos_r == 32'h0000_0000)
    else $error("mode 5 did not clear at bound");
  chk_mode0_hold: assert property (
    run && mode == 3'h0 && !up && !down && !wr_en |=> $stable(pos_r))
    else $error("mode 0 position moved without count");
  chk_sleep_hold: assert property (
    sleep_mode && !wr_en |=> $stable(pos_r) && !$past(idx_ev))
    else $error("position changed in sleep");
  chk_home_capture: assert property (
    home_ev && ioc_r[15] |=> ic_r == $past(pos_r))
    else $error("home capture missed");
  chk_irq_merge: assert property (
    stat_r[13] && stat_r[12] |-> irq)
    else $error("enabled flag not on interrupt");
  chk_filter_stable: assert property (
    ioc_r[14] && $past(ioc_r[14], 3) && $changed(filt[2]) |->
      $past(raw_in[2], 1) == filt[2] && $past(raw_in[2], 2) == filt[2])
    else $error("filter passed an unstable level");

  cov_mode2_load: cover property (mode == 3'h2 && idx_ev);
  cov_home_load: cover property (mode == 3'h4 && idx_ev &&
                                 home_seq_r == 2'h2);
  cov_modulo_wrap: cover property (mode == 3'h7 && up && pos_r == ic_r);
  cov_irq_rise: cover property (!irq ##1 irq);

endmodule

// *** quad_enc_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// incremental encoder with index and home sensor
module quad_enc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // motion requests from the bench
  input wire logic up_req,
  input wire logic dn_req,
  input wire logic idx_req,
  input wire logic home_req,
  // sensor lines and decoder pulses
  output logic ph_a,
  output logic ph_b,
  output logic idx,
  output logic home,
  output logic cnt_up,
  output logic cnt_dn
);
  logic [1:0] st_r;
  // states 00,10,11,01 in turn: phase a leads phase b on up counts
  assign ph_a = st_r[1] ^ st_r[0];
  assign ph_b = st_r[1];
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= 2'h0;
      {idx, home, cnt_up, cnt_dn} <= 4'h0;
    end
    else
    begin
      st_r <= st_r + {1'b0, up_req} - {1'b0, dn_req};
      idx <= idx_req;
      home <= home_req;
      // a real decoder never reports both directions in one cycle
      cnt_up <= up_req & ~dn_req;
      cnt_dn <= dn_req & ~up_req;
    end
  end
endmodule

// *** test_encoder_position_compare_init.sv ***
`timescale 1ns/100ps
module test_encoder_position_compare_init;
  // ==========================================================
  // signals and bench model state
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e, run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, m_pos, m_ic, m_gec, m_lec;
  logic ph_a, ph_b, idx, home, cup, cdn, vel_ovf, sleep_mode, idle_mode;
  logic a_dec, b_dec, cmp_pin, irq, up_req, dn_req, idx_req, home_req;
  logic [2:0] m_mode;
  int n_mismatch, total_checks, homes, t;
  encoder_position_compare_init encoder_position_compare_init_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phase_a_input(ph_a),
    .phase_b_input(ph_b), .index_pulse_input(idx), .home_input(home),
    .count_up_pulse(cup), .count_down_pulse(cdn),
    .vel_ovf_event(vel_ovf), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .phase_a_dec(a_dec), .phase_b_dec(b_dec),
    .compare_out_pin(cmp_pin), .irq(irq));
  quad_enc_model quad_enc_model_inst (
    .clk(clk), .rst(rst), .up_req(up_req), .dn_req(dn_req),
    .idx_req(idx_req), .home_req(home_req), .ph_a(ph_a), .ph_b(ph_b),
    .idx(idx), .home(home), .cnt_up(cup), .cnt_dn(cdn));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // checking and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] x);
    total_checks++;
    if (got !== x)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, x);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(q & m, x);
  endtask
  task automatic setmode(input logic [2:0] m, input logic s, input logic x);
    wr(enc_pkg::CTRL_OFS, {18'h0, s, m, ph_b ^ x, ph_a ^ x, 8'h0});
    m_mode = m;
    homes = -1;
  endtask
  // ==========================================================
  // stimulus with model updates
  function automatic logic [31:0] nxt(input logic up);
    logic [31:0] p;
    p = up ? m_pos + 32'h1 : m_pos - 32'h1;
    if (m_mode == 3'h6 && up && m_pos == m_gec) p = m_lec;
    if (m_mode == 3'h6 && !up && m_pos == m_lec) p = m_gec;
    if (m_mode == 3'h7 && up && m_pos == m_ic) p = m_lec;
    if (m_mode == 3'h7 && !up && m_pos == m_lec) p = m_ic;
    if (m_mode == 3'h5 && p == m_gec) p = 32'h0;
    return p;
  endfunction
  task automatic idx_model();
    logic ld;
    if (homes >= 0) homes++;
    ld = m_mode == 3'h2 || (m_mode == 3'h3 && homes == 1) ||
      (m_mode == 3'h4 && homes == 2);
    if (ld) m_pos = m_ic;
    if (ld) m_mode = 3'h0;
    if (m_mode == 3'h1 || m_mode == 3'h7) m_pos = 32'h0;
  endtask
  task automatic step(input logic up, input int n);
    repeat (n)
    begin
      @(posedge clk);
      up_req <= up;
      dn_req <= ~up;
      @(posedge clk);
      up_req <= 1'b0;
      dn_req <= 1'b0;
      if (run) m_pos = nxt(up);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse(input logic hm, input int len, input int post);
    @(posedge clk);
    idx_req <= ~hm;
    home_req <= hm;
    repeat (len) @(posedge clk);
    idx_req <= 1'b0;
    home_req <= 1'b0;
    repeat (post) @(posedge clk);
  endtask
  task automatic pins();
    logic ge, le;
    ge = $signed(m_pos) >= $signed(m_gec);
    le = $signed(m_pos) <= $signed(m_lec);
    for (int f = 0; f < 4; f++)
    begin
      wr(enc_pkg::IOC_OFS, 32'(f) << 9);
      repeat (3) @(posedge clk);
      check(cmp_pin, f == 1 ? ge : f == 2 ? le : f == 3 ? ge | le : 0);
    end
  endtask
  initial
  begin
    // a hang in any handshake ends the run here
    repeat (30000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, vel_ovf} = '0;
    {up_req, dn_req, idx_req, home_req, sleep_mode, idle_mode} = '0;
    {m_pos, m_ic, m_gec, m_lec, m_mode, n_mismatch, total_checks} = '0;
    rst = 1'b1;
    run = 1'b1;
    homes = -1;
    void'($urandom(32'hB9169F88));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // compare flags come up at once since position equals both bounds
    for (int a = 0; a < 7; a++) rd(8'(4 * a), a == 2 ? 32'hD7FF : ALL, 0);
    apb(1'b0, 8'h1C, 32'h0);
    check(q, 32'h0);
    check(e, 32'h1);
    $display("test reset done");
    m_gec = 32'($urandom_range(9, 2));
    m_lec = 32'hFFFF_FFFD;
    wr(enc_pkg::GEC_OFS, m_gec);
    wr(enc_pkg::LEC_OFS, m_lec);
    wr(enc_pkg::STAT_OFS, 32'h2AAA);
    wr(enc_pkg::STAT_OFS, 32'h1000);
    rd(enc_pkg::STAT_OFS, 32'h2800, 32'h0);
    check(irq, 32'h0);
    step(1'b1, m_gec + $urandom_range(3, 0));
    rd(enc_pkg::STAT_OFS, 32'h2800, 32'h2000);
    check(irq, 32'h1);
    pins();
    step(1'b0, m_pos + 4);
    rd(enc_pkg::STAT_OFS, 32'h0800, 32'h0800);
    pins();
    @(posedge clk);
    vel_ovf <= 1'b1;
    @(posedge clk);
    vel_ovf <= 1'b0;
    rd(enc_pkg::STAT_OFS, 32'h0020, 32'h0020);
    m_pos = 32'h7FFF_FFFF;
    wr(enc_pkg::POS_OFS, m_pos);
    step(1'b1, 1);
    rd(enc_pkg::STAT_OFS, 32'h0200, 32'h0200);
    $display("test compare done");
    setmode(3'h1, 1'b0, 1'b1);
    pulse(1'b0, 3, 6);
    rd(enc_pkg::POS_OFS, ALL, m_pos);
    setmode(3'h1, 1'b0, 1'b0);
    @(posedge clk);
    idx_req <= 1'b1;
    repeat (6) @(posedge clk);
    idx_model();
    // four counts bring the phases back to the match state
    step(1'b1, 4);
    idx_req <= 1'b0;
    rd(enc_pkg::POS_OFS, ALL, m_pos);
    rd(enc_pkg::STAT_OFS, 32'h0002, 32'h0002);
    setmode(3'h0, 1'b0, 1'b0);
    pulse(1'b0, 3, 6);
    rd(enc_pkg::POS_OFS, ALL, m_pos);
    for (int m = 2; m < 5; m++)
    begin
      m_ic = $urandom;
      wr(enc_pkg::IC_OFS, m_ic);
      setmode(3'(m), 1'b0, 1'b0);
      if (m > 2) pulse(1'b0, 3, 6);
      if (m > 2) idx_model();
      if (m > 2) pulse(1'b1, 3, 6);
      homes = 0;
      for (int k = 0; k < 2; k++)
      begin
        pulse(1'b0, 3, 6);
        idx_model();
        rd(enc_pkg::POS_OFS, ALL, m_pos);
      end
      rd(enc_pkg::CTRL_OFS, 32'h1C00, 32'h0);
      rd(enc_pkg::STAT_OFS, 32'h0080, 32'h0080);
    end
    $display("test index done");
    m_gec = m_pos + 32'h3;
    wr(enc_pkg::GEC_OFS, m_gec);
    setmode(3'h5, 1'b0, 1'b0);
    step(1'b1, 3);
    rd(enc_pkg::POS_OFS, ALL, m_pos);
    setmode(3'h0, 1'b0, 1'b0);
    m_gec = 32'h2;
    m_lec = 32'hFFFF_FFFE;
    m_ic = 32'h3;
    wr(enc_pkg::GEC_OFS, m_gec);
    wr(enc_pkg::LEC_OFS, m_lec);
    wr(enc_pkg::IC_OFS, m_ic);
    for (int m = 6; m < 8; m++)
    begin
      setmode(3'(m), 1'b0, 1'b0);
      step(1'b1, 6);
      rd(enc_pkg::POS_OFS, ALL, m_pos);
      step(1'b0, 9);
      rd(enc_pkg::POS_OFS, ALL, m_pos);
    end
    setmode(3'h7, 1'b0, 1'b0);
    pulse(1'b0, 3, 6);
    idx_model();
    rd(enc_pkg::POS_OFS, ALL, m_pos);
    $display("test modes done");
    setmode(3'h0, 1'b0, 1'b0);
    wr(enc_pkg::IOC_OFS, 32'h01F0);
    rd(enc_pkg::IOC_OFS, 32'hF, {30'h3, ~ph_b, ~ph_a});
    check(a_dec, !ph_b);
    check(b_dec, !ph_a);
    wr(enc_pkg::IOC_OFS, 32'h8000);
    wr(enc_pkg::STAT_OFS, 32'h0008);
    pulse(1'b1, 3, 6);
    m_ic = m_pos;
    rd(enc_pkg::IC_OFS, ALL, m_ic);
    rd(enc_pkg::STAT_OFS, 32'h0008, 32'h0008);
    t = $urandom_range(3, 0);
    wr(enc_pkg::IOC_OFS, 32'h4000 | (32'(t) << 11));
    t = 1 << t;
    step(1'b1, 2);
    repeat (40) @(posedge clk);
    setmode(3'h1, 1'b0, 1'b0);
    pulse(1'b0, 2 * t, 8 * t);
    rd(enc_pkg::POS_OFS, ALL, m_pos);
    pulse(1'b0, 5 * t, 8 * t);
    idx_model();
    rd(enc_pkg::POS_OFS, ALL, m_pos);
    $display("test inputs done");
    wr(enc_pkg::IOC_OFS, 32'h0);
    setmode(3'h0, 1'b1, 1'b0);
    for (int s = 0; s < 3; s++)
    begin
      @(posedge clk);
      sleep_mode <= s == 0;
      idle_mode <= s != 0;
      if (s == 2) setmode(3'h0, 1'b0, 1'b0);
      run = s == 2;
      step(1'b1, 3);
      rd(enc_pkg::POS_OFS, ALL, m_pos);
    end
    $display("test power done");
    stop_test();
  end
endmodule
